// ### common/rbcfg_pkg.sv
// Functional notes
// - Start-up voltage code in 0x60 bits 7:4; code 0000 keeps rail off
// - Low nibble of 0x60 is reserved, default 1000
// - Offset 0x61 reserved default 8Ch; offset 0x62 reserved default 32h
// - Bit 7 of 0x64 enables soft-start overcurrent protection
// - Soft-start limit equals current scale times ratio; ratio 000 means 1.25
// - Bits 2:0 of 0x64 pick current scale; 000 custom, 001-111 doubling from 31.96875 A
// - Bits 7:4 of 0x65 reserved, default 1110
// - Bit 3 of 0x65 enables zero droop operation
// - Bits 2:0 of 0x65 give sense amplifier gain per fixed table
// - Voltage code mirrors into interface reg 08h[3:0], scale into 09h[5:3]
package rbcfg_pkg;
  localparam logic [7:0] OFS_BOOT = 8'h60;
  localparam logic [7:0] OFS_RSVA = 8'h61;
  localparam logic [7:0] OFS_RSVB = 8'h62;
  localparam logic [7:0] OFS_SSOC = 8'h64;
  localparam logic [7:0] OFS_GAIN = 8'h65;
  localparam logic [7:0] RST_BOOT = 8'h08;
  localparam logic [7:0] RST_RSVA = 8'h8c;
  localparam logic [7:0] RST_RSVB = 8'h32;
  localparam logic [7:0] RST_SSOC = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'he0;
  localparam logic [7:0] RSV_MASK_SSOC = 8'h08;
  localparam logic [7:0] RSV_BOOT_LO = 8'h08;
  localparam logic [7:0] RSV_GAIN_HI = 8'he0;
  localparam int VC_POS = 4;
  localparam int SSOC_EN_POS = 7;
  localparam int RATIO_POS = 4;
  localparam int ZD_POS = 3;
  // Voltage in mV, 12 bits
  localparam logic [11:0] MV_STEP = 12'h064;
  localparam logic [11:0] MV_BASE = 12'h190;
  // Current scale LSB = 1/32 A: 31.96875 A = 1023/32
  localparam logic [31:0] SCALE1_Q5 = 32'h0000_03ff;
  // Ratio 000 = 1.25 = 5/4 in quarter units
  localparam logic [3:0] RATIO0_Q2 = 4'h5;
  typedef struct packed {
    logic [3:0] startup_voltage_code;
    logic [11:0] startup_mv;
    logic rail_off;
    logic softstart_overcurrent_enable;
    logic [2:0] softstart_overcurrent_ratio;
    logic [2:0] scale_code;
    logic scale_custom;
    logic [31:0] scale_q5;
    logic [31:0] softstart_overcurrent_limit_q7;
    logic zero_droop_enable;
    logic [9:0] sense_amp_gain_q3;
    logic [7:0] iface_08h;
    logic [7:0] iface_09h;
  } rbcfg_cfg_t;
endpackage

// ### rtl/rbcfg_decode.sv
`timescale 1ns/1ns
module rbcfg_decode (
  // Register contents
  input wire logic [7:0] boot_reg,
  input wire logic [7:0] ssoc_reg,
  input wire logic [7:0] gain_reg,
  // Decoded settings
  output rbcfg_pkg::rbcfg_cfg_t cfg
);
  function automatic logic [11:0] volt_mv(input logic [3:0] c);
    unique case (c)
      4'h0: volt_mv = 12'h000;
      4'hc: volt_mv = 12'h708;
      4'hd: volt_mv = 12'h7d0;
      4'he: volt_mv = 12'h9c4;
      4'hf: volt_mv = 12'haf0;
      default: volt_mv = 12'(rbcfg_pkg::MV_BASE + 12'(c) * rbcfg_pkg::MV_STEP);
    endcase
  endfunction
  // Gain in thousandths
  function automatic logic [9:0] gain_q(input logic [2:0] g);
    unique case (g)
      3'h0: gain_q = 10'h0fa;
      3'h1: gain_q = 10'h1f4;
      3'h2: gain_q = 10'h2ee;
      3'h3: gain_q = 10'h3e8;
      3'h4: gain_q = 10'h07d;
      3'h5: gain_q = 10'h177;
      3'h6: gain_q = 10'h271;
      3'h7: gain_q = 10'h36b;
    endcase
  endfunction
  wire logic [3:0] vcode = boot_reg[rbcfg_pkg::VC_POS +: 4];
  wire logic [2:0] ratio = ssoc_reg[rbcfg_pkg::RATIO_POS +: 3];
  wire logic [2:0] sc = ssoc_reg[2:0];
  wire logic [31:0] scale = (sc == 3'h0) ? 32'h0 : (rbcfg_pkg::SCALE1_Q5 << (sc - 3'h1));
  wire logic [3:0] ratio_q2 = rbcfg_pkg::RATIO0_Q2 + {1'b0, ratio};
  wire logic [31:0] limit = 32'(scale * 32'(ratio_q2));
  assign cfg.startup_voltage_code = vcode;
  assign cfg.startup_mv = volt_mv(vcode);
  assign cfg.rail_off = (vcode == 4'h0);
  assign cfg.softstart_overcurrent_enable = ssoc_reg[rbcfg_pkg::SSOC_EN_POS];
  assign cfg.softstart_overcurrent_ratio = ratio;
  assign cfg.scale_code = sc;
  assign cfg.scale_custom = (sc == 3'h0);
  assign cfg.scale_q5 = scale;
  assign cfg.softstart_overcurrent_limit_q7 = limit;
  assign cfg.zero_droop_enable = gain_reg[rbcfg_pkg::ZD_POS];
  assign cfg.sense_amp_gain_q3 = gain_q(gain_reg[2:0]);
  assign cfg.iface_08h = {4'h0, vcode};
  assign cfg.iface_09h = {2'h0, sc, 3'h0};
endmodule // rbcfg_decode

// ### rtl/rbcfg_regs.sv
`timescale 1ns/1ns
module rbcfg_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Settings to converter
  output rbcfg_pkg::rbcfg_cfg_t cfg_ff
);
  logic [7:0] boot_ff, rsva_ff, rsvb_ff, ssoc_ff, gain_ff;
  rbcfg_pkg::rbcfg_cfg_t dec;
  wire logic wr_boot = reg_wr && reg_addr == rbcfg_pkg::OFS_BOOT;
  wire logic wr_rsva = reg_wr && reg_addr == rbcfg_pkg::OFS_RSVA;
  wire logic wr_rsvb = reg_wr && reg_addr == rbcfg_pkg::OFS_RSVB;
  wire logic wr_ssoc = reg_wr && reg_addr == rbcfg_pkg::OFS_SSOC;
  wire logic wr_gain = reg_wr && reg_addr == rbcfg_pkg::OFS_GAIN;
  // Read mux: unmapped addresses read zero
  wire logic [7:0] nxt_rdata =
    (reg_addr == rbcfg_pkg::OFS_BOOT) ? boot_ff :
    (reg_addr == rbcfg_pkg::OFS_RSVA) ? rsva_ff :
    (reg_addr == rbcfg_pkg::OFS_RSVB) ? rsvb_ff :
    (reg_addr == rbcfg_pkg::OFS_SSOC) ? ssoc_ff :
    (reg_addr == rbcfg_pkg::OFS_GAIN) ? gain_ff : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      boot_ff <= rbcfg_pkg::RST_BOOT;
      rsva_ff <= rbcfg_pkg::RST_RSVA;
      rsvb_ff <= rbcfg_pkg::RST_RSVB;
      ssoc_ff <= rbcfg_pkg::RST_SSOC;
      gain_ff <= rbcfg_pkg::RST_GAIN;
    end else begin
      if (wr_boot) boot_ff <= reg_wdata;
      if (wr_rsva) rsva_ff <= reg_wdata;
      if (wr_rsvb) rsvb_ff <= reg_wdata;
      if (wr_ssoc) ssoc_ff <= reg_wdata;
      if (wr_gain) gain_ff <= reg_wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end
  rbcfg_decode u_dec (
    .boot_reg(boot_ff),
    .ssoc_reg(ssoc_ff),
    .gain_reg(gain_ff),
    .cfg(dec)
  );
  always_ff @(posedge sys_clk) begin
    cfg_ff <= dec;
  end
  // Checks
  AST_RST_BOOT: assert property (@(posedge sys_clk) reset |=> boot_ff == 8'h08)
    else $error("Boot register reset wrong");
  AST_RST_RSV: assert property (@(posedge sys_clk) reset |=> rsva_ff == 8'h8c && rsvb_ff == 8'h32)
    else $error("Reserved reset wrong");
  AST_RST_SSOC: assert property (@(posedge sys_clk) reset |=> ssoc_ff[3] == 1'b0)
    else $error("Ssoc reserved bit wrong");
  AST_RST_GAIN: assert property (@(posedge sys_clk) reset |=> gain_ff[7:4] == 4'he)
    else $error("Gain reserved nibble wrong");
  AST_RAIL_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    wr_boot && reg_wdata[7:4] == 4'h0 ##1 1'b1 ##1 1'b1 |-> cfg_ff.rail_off)
    else $error("Rail off not decoded");
  AST_VOLT: assert property (@(posedge sys_clk) disable iff (reset)
    wr_boot && reg_wdata[7:4] == 4'hd |-> ##2 cfg_ff.startup_mv == 12'h7d0)
    else $error("Voltage decode wrong");
  AST_SSOC_EN: assert property (@(posedge sys_clk) disable iff (reset)
    wr_ssoc |-> ##2 cfg_ff.softstart_overcurrent_enable == $past(reg_wdata[7], 2))
    else $error("Ssoc enable mismatch");
  AST_LIMIT: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_ff.scale_code == 3'h1 && cfg_ff.softstart_overcurrent_ratio == 3'h0
    |-> cfg_ff.softstart_overcurrent_limit_q7 == 32'h0000_13fb)
    else $error("Limit wrong");
  AST_SCALE: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_ff.scale_code == 3'h7 |-> cfg_ff.scale_q5 == 32'h0000_ffc0)
    else $error("Scale wrong");
  AST_ZD: assert property (@(posedge sys_clk) disable iff (reset)
    wr_gain |-> ##2 cfg_ff.zero_droop_enable == $past(reg_wdata[3], 2))
    else $error("Zero droop mismatch");
  AST_GAIN: assert property (@(posedge sys_clk) disable iff (reset)
    wr_gain && reg_wdata[2:0] == 3'h4 ##1 !wr_gain |=> cfg_ff.sense_amp_gain_q3 == 10'h07d)
    else $error("Gain decode wrong");
  AST_MIRROR: assert property (@(posedge sys_clk) disable iff (reset)
    wr_ssoc |-> ##2 cfg_ff.iface_09h[5:3] == $past(reg_wdata[2:0], 2))
    else $error("Scale mirror wrong");
  AST_MIRROR_VC: assert property (@(posedge sys_clk) disable iff (reset)
    wr_boot |-> ##2 cfg_ff.iface_08h[3:0] == $past(reg_wdata[7:4], 2))
    else $error("Voltage mirror wrong");
  AST_RDATA: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && reg_addr == rbcfg_pkg::OFS_GAIN && !reg_wr |=> reg_rdata_ff == gain_ff)
    else $error("Read data wrong");
  COV_WR_BOOT: cover property (@(posedge sys_clk) wr_boot ##[1:8] reg_rd);
  COV_SSOC_ON: cover property (@(posedge sys_clk) cfg_ff.softstart_overcurrent_enable);
  COV_ZD_ON: cover property (@(posedge sys_clk) cfg_ff.zero_droop_enable);
endmodule // rbcfg_regs

// ### test/rbcfg_bench.sv
`timescale 1ns/1ns
module rbcfg_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_ff;
  rbcfg_pkg::rbcfg_cfg_t cfg_ff;
  int mismatches = 0;
  int cmp_count = 0;
  logic [11:0] mv_hi [4] = '{12'h708, 12'h7d0, 12'h9c4, 12'haf0};
  logic [9:0] gain_tab [8] = '{10'h0fa, 10'h1f4, 10'h2ee, 10'h3e8, 10'h07d, 10'h177, 10'h271,
    10'h36b};
  logic [31:0] scale;

  always #2 sys_clk = ~sys_clk;

  rbcfg_regs dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff),
    .cfg_ff(cfg_ff)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write, then wait until the settings have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // One-cycle read; data checked in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata_ff, exp);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h60, 8'h08);
    rd(8'h61, 8'h8c);
    rd(8'h62, 8'h32);
    rd(8'h64, 8'h00);
    rd(8'h65, 8'he0);
    chk(cfg_ff.rail_off, 1);
    for (int i = 0; i < 16; i++) begin
      wr(8'h60, {i[3:0], 4'h8});
      chk(cfg_ff.startup_voltage_code, i);
      chk(cfg_ff.rail_off, i == 0);
      if (i > 0) chk(cfg_ff.startup_mv, i < 12 ? 400 + 100 * i : mv_hi[i - 12]);
      chk(cfg_ff.iface_08h[3:0], i);
      rd(8'h60, {i[3:0], 4'h8});
    end
    for (int i = 0; i < 8; i++) begin
      scale = (i == 0) ? 32'h0000_0000 : (32'h0000_03ff << (i - 1));
      wr(8'h64, {i[0], i[2:0], 1'b0, i[2:0]});
      chk(cfg_ff.softstart_overcurrent_enable, i % 2);
      chk(cfg_ff.scale_code, i);
      chk(cfg_ff.softstart_overcurrent_ratio, i);
      chk(cfg_ff.scale_custom, i == 0);
      chk(cfg_ff.scale_q5, scale);
      chk(cfg_ff.softstart_overcurrent_limit_q7, scale * (5 + i));
      chk(cfg_ff.iface_09h[5:3], i);
      rd(8'h64, {i[0], i[2:0], 1'b0, i[2:0]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h65, {4'he, i[0], i[2:0]});
      chk(cfg_ff.zero_droop_enable, i % 2);
      chk(cfg_ff.sense_amp_gain_q3, gain_tab[i]);
    end
    wr(8'h63, 8'hff);
    rd(8'h63, 8'h00);
    rd(8'h65, 8'hef);
    rd(8'h61, 8'h8c);
    wr(8'h64, 8'h01);
    chk(cfg_ff.softstart_overcurrent_limit_q7, 32'h0000_13fb);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h60, 8'h08);
    rd(8'h64, 8'h00);
    rd(8'h65, 8'he0);
    chk(cfg_ff.rail_off, 1);
    chk(cfg_ff.sense_amp_gain_q3, 10'h0fa);
    end_of_test();
  end
endmodule // rbcfg_bench
